// *** core/chan_ctl_pkg.sv ***
package chan_ctl_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] status_addr = 8'h0b;
  localparam logic [7:0] command_addr = 8'h0c;
  localparam logic [7:0] irq_status_addr = 8'h10;
  localparam logic [7:0] irq_enable_addr = 8'h14;
  localparam logic [7:0] irq_clear_addr = 8'h18;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] ier_reset = 8'h00;
  // Command byte formats
  localparam logic [7:0] fmt_reset_mask = 8'hfc;
  localparam logic [7:0] fmt_reset_val = 8'h80;
  localparam logic [7:0] fmt_ctl_mask = 8'hf0;
  localparam logic [7:0] fmt_ctl_val = 8'h10;
  localparam logic [7:0] fmt_send_mask = 8'hf8;
  localparam logic [7:0] fmt_send_val = 8'h20;
  // Command field positions
  localparam int tx_en_bit = 3;
  localparam int tx_dis_bit = 2;
  localparam int rx_en_bit = 1;
  localparam int rx_dis_bit = 0;
  localparam int reset_type_bit = 0;
  localparam int reset_ftf_bit = 1;
  localparam logic [2:0] send_xon = 3'h1;
  localparam logic [2:0] send_xoff = 3'h2;
  // Status bit positions
  localparam int st_rx_en = 7;
  localparam int st_rx_floff = 6;
  localparam int st_rx_flon = 5;
  localparam int st_tx_en = 3;
  localparam int st_tx_floff = 2;
  localparam int st_tx_flon = 1;
  // Interrupt event positions
  localparam int ev_tx_floff = 0;
  localparam int ev_tx_flon = 1;
  localparam int ev_bad_cmd = 2;
  localparam int ev_width = 3;
endpackage

// *** core/cmd_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmd_decode
  import chan_ctl_pkg::*;
(
  input wire logic [7:0] cmd,
  input wire logic valid,
  output logic ctl,
  output logic chan_reset,
  output logic send_xon_cmd,
  output logic send_xoff_cmd,
  output logic unknown
);
  // Pure format classification of one command byte
  always_comb begin
    ctl = valid && ((cmd & fmt_ctl_mask) == fmt_ctl_val);
    chan_reset = valid && ((cmd & fmt_reset_mask) == fmt_reset_val) &&
      !cmd[reset_type_bit] && !cmd[reset_ftf_bit];
    send_xon_cmd = valid && ((cmd & fmt_send_mask) == fmt_send_val) && cmd[2:0] == send_xon;
    send_xoff_cmd = valid && ((cmd & fmt_send_mask) == fmt_send_val) && cmd[2:0] == send_xoff;
    unknown = valid && !ctl && ((cmd & fmt_reset_mask) != fmt_reset_val) &&
      ((cmd & fmt_send_mask) != fmt_send_val);
  end
endmodule // cmd_decode
`default_nettype wire

// *** core/chan_ctl.sv ***
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module chan_ctl
  import chan_ctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_xoff_seen,
  input wire logic rx_xon_seen,
  input wire logic rx_data_seen,
  input wire logic tx_started,
  output logic receiver_enabled,
  output logic transmitter_enabled,
  output logic transmit_halted,
  output logic send_special_one,
  output logic send_special_two,
  output logic fifo_flush,
  output logic irq
);
  typedef struct packed {
    logic rx_en;
    logic rx_floff;
    logic rx_flon;
    logic tx_en;
    logic tx_floff;
    logic tx_flon;
    logic [ev_width-1:0] ev;
    logic [ev_width-1:0] ev_en;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic sc1;
    logic sc2;
    logic flush;
    logic irq;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  logic acc;
  logic commit;
  logic wr_cmd;
  logic ctl;
  logic chan_reset;
  logic xon_cmd;
  logic xoff_cmd;
  logic unknown;
  logic [7:0] cmd;
  logic [7:0] status_byte;

  // Ready follows the first access cycle; read data is captured there
  assign acc = psel && penable && !state_r.ready;
  // Writes land only at the edge where the master samples ready high
  assign commit = psel && penable && state_r.ready;
  assign wr_cmd = commit && pwrite && paddr == command_addr;
  assign cmd = pwdata[7:0];

  cmd_decode u_dec (
    .cmd(cmd),
    .valid(wr_cmd),
    .ctl(ctl),
    .chan_reset(chan_reset),
    .send_xon_cmd(xon_cmd),
    .send_xoff_cmd(xoff_cmd),
    .unknown(unknown)
  );

  // Status byte assembly
  always_comb begin
    status_byte = 8'h00;
    status_byte[st_rx_en] = state_r.rx_en;
    status_byte[st_rx_floff] = state_r.rx_floff;
    status_byte[st_rx_flon] = state_r.rx_flon;
    status_byte[st_tx_en] = state_r.tx_en;
    status_byte[st_tx_floff] = state_r.tx_floff;
    status_byte[st_tx_flon] = state_r.tx_flon;
    status_byte[4] = 1'b0;
    status_byte[0] = 1'b0;
  end

  // Next-state logic: commands, line events, bus answer
  always_comb begin
    state_nxt = state_r;
    state_nxt.ready = acc;
    state_nxt.err = 1'b0;
    state_nxt.sc1 = 1'b0;
    state_nxt.sc2 = 1'b0;
    state_nxt.flush = 1'b0;
    if (ctl) begin
      if (cmd[tx_en_bit] && !cmd[tx_dis_bit]) begin
        state_nxt.tx_en = 1'b1;
      end else if (cmd[tx_dis_bit] && !cmd[tx_en_bit]) begin
        state_nxt.tx_en = 1'b0;
      end
      if (cmd[rx_en_bit] && !cmd[rx_dis_bit]) begin
        state_nxt.rx_en = 1'b1;
      end else if (cmd[rx_dis_bit] && !cmd[rx_en_bit]) begin
        state_nxt.rx_en = 1'b0;
      end
      // host override of remote flow control
      state_nxt.tx_floff = 1'b0;
      state_nxt.tx_flon = 1'b0;
      state_nxt.rx_floff = 1'b0;
      if (cmd[rx_en_bit] || cmd[rx_dis_bit]) begin
        state_nxt.rx_flon = 1'b0;
      end
      // no configuration register is touched here
    end
    if (xon_cmd) begin
      state_nxt.sc1 = 1'b1;
      state_nxt.rx_floff = 1'b0;
      state_nxt.rx_flon = 1'b1;
    end
    if (xoff_cmd) begin
      state_nxt.sc2 = 1'b1;
      state_nxt.rx_floff = 1'b1;
    end
    if (rx_data_seen) begin
      state_nxt.rx_flon = 1'b0;
    end
    if (tx_started) begin
      state_nxt.tx_flon = 1'b0;
    end
    if (rx_xoff_seen && !ctl) begin
      state_nxt.tx_floff = 1'b1;
    end
    if (rx_xon_seen && !ctl) begin
      state_nxt.tx_floff = 1'b0;
      state_nxt.tx_flon = 1'b1;
    end
    if (chan_reset) begin
      state_nxt.rx_en = 1'b0;
      state_nxt.tx_en = 1'b0;
      state_nxt.rx_floff = 1'b0;
      state_nxt.rx_flon = 1'b0;
      state_nxt.tx_floff = 1'b0;
      state_nxt.tx_flon = 1'b0;
      state_nxt.flush = 1'b1;
    end
    // Interrupt: clear first so a same-cycle event wins
    if (commit && pwrite && paddr == irq_clear_addr) begin
      state_nxt.ev = state_r.ev & ~pwdata[ev_width-1:0];
    end
    if (commit && pwrite && paddr == irq_enable_addr) begin
      state_nxt.ev_en = pwdata[ev_width-1:0];
    end
    if (rx_xoff_seen) begin
      state_nxt.ev[ev_tx_floff] = 1'b1;
    end
    if (rx_xon_seen) begin
      state_nxt.ev[ev_tx_flon] = 1'b1;
    end
    if (unknown) begin
      state_nxt.ev[ev_bad_cmd] = 1'b1;
    end
    state_nxt.irq = |(state_nxt.ev & state_nxt.ev_en);
    // Read data mux; unmapped addresses answer with an error
    state_nxt.rdata = 32'h0000_0000;
    if (acc) begin
      case (paddr)
        status_addr: state_nxt.rdata = {24'h000000, status_byte};
        irq_status_addr: state_nxt.rdata = {29'h0, state_r.ev};
        irq_enable_addr: state_nxt.rdata = {29'h0, state_r.ev_en};
        command_addr: state_nxt.rdata = 32'h0000_0000;
        irq_clear_addr: state_nxt.rdata = 32'h0000_0000;
        default: state_nxt.err = 1'b1;
      endcase
      // Status is read-only, writing it is refused
      if (pwrite && paddr == status_addr) begin
        state_nxt.err = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = state_r.rdata;
  assign pready = state_r.ready;
  assign pslverr = state_r.err;
  assign receiver_enabled = state_r.rx_en;
  assign transmitter_enabled = state_r.tx_en;
  assign transmit_halted = state_r.tx_floff;
  assign send_special_one = state_r.sc1;
  assign send_special_two = state_r.sc2;
  assign fifo_flush = state_r.flush;
  assign irq = state_r.irq;
endmodule // chan_ctl
`default_nettype wire

// *** tb/chan_ctl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module chan_ctl_props
  import chan_ctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic rx_xoff_seen,
  input wire logic receiver_enabled,
  input wire logic transmitter_enabled,
  input wire logic transmit_halted,
  input wire logic fifo_flush,
  input wire logic send_special_one,
  input wire logic send_special_two
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Command write taken at this edge, and its control form
  logic cw;
  logic ctl;
  assign cw = psel && penable && pready && pwrite && paddr == command_addr;
  assign ctl = cw && pwdata[7:4] == 4'h1;
  AST_READY_NEXT: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access");
  AST_RSVD_ZERO: assert property (
    pready && !pwrite && paddr == status_addr |-> !prdata[4] && !prdata[0])
    else $error("reserved status bit set");
  AST_TX_ON: assert property (
    ctl && pwdata[3:2] == 2'b10 |-> ##[1:2] transmitter_enabled) else $error("tx not on");
  AST_RX_OFF: assert property (
    ctl && pwdata[1:0] == 2'b01 |-> ##[1:2] !receiver_enabled) else $error("rx not off");
  AST_CONFLICT: assert property (
    ctl && pwdata[3:2] == 2'b11 |-> ##2 transmitter_enabled == $past(transmitter_enabled, 2))
    else $error("tx changed on conflict");
  AST_RESTART: assert property (
    ctl |-> ##2 (!transmit_halted || $past(rx_xoff_seen))) else $error("still halted");
  AST_HALT_SET: assert property (
    rx_xoff_seen && !cw |-> ##[1:2] transmit_halted) else $error("no halt on xoff");
  AST_CHAN_RESET: assert property (
    cw && pwdata[7:0] == 8'h80 |-> ##[1:2] fifo_flush ##[0:1] !receiver_enabled
    && !transmitter_enabled) else $error("reset not applied");
  AST_SEND_ONE: assert property (
    cw && pwdata[7:0] == 8'h21 |=> send_special_one) else $error("no special one pulse");
  AST_SEND_TWO: assert property (
    cw && pwdata[7:0] == 8'h22 |=> send_special_two) else $error("no special two pulse");
endmodule // chan_ctl_props
bind chan_ctl chan_ctl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .rx_xoff_seen(rx_xoff_seen), .receiver_enabled(receiver_enabled),
  .transmitter_enabled(transmitter_enabled), .transmit_halted(transmit_halted),
  .fifo_flush(fifo_flush), .send_special_one(send_special_one),
  .send_special_two(send_special_two));
`default_nettype wire

// *** tb/remote_line.sv ***
`timescale 1ns/1ps
`default_nettype none
module remote_line (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [3:0] req,
  output logic [3:0] ev
);
  logic [7:0] d_r;
  // Line latency of one or two cycles; quiet lines rest low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_r <= 8'h00;
    end else begin
      d_r <= {d_r[3:0], req};
    end
  end
  assign ev = slow ? d_r[7:4] : d_r[3:0];
endmodule // remote_line
`default_nettype wire

// *** tb/test_chan_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_chan_ctl
  import chan_ctl_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00, st = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h0bb71838;
  logic [3:0] req = 4'h0, ev;
  logic [32:0] exp_q[$];
  logic pready, pslverr, halted, irq;
  int errors = 0, n_checks = 0;
  chan_ctl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_xoff_seen(ev[0]), .rx_xon_seen(ev[1]), .rx_data_seen(ev[2]),
    .tx_started(ev[3]), .receiver_enabled(), .transmitter_enabled(), .transmit_halted(halted),
    .send_special_one(), .send_special_two(), .fifo_flush(), .irq(irq));
  remote_line far (.pclk(pclk), .presetn(presetn), .slow(slow), .req(req), .ev(ev));
  always #5 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One transfer; an idle cycle follows so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] x);
    apb(1'b0, status_addr, 32'h0, {25'h0, x});
  endtask
  // Control command, then status read against the model
  task automatic ctl(input logic [3:0] n);
    apb(1'b1, command_addr, {rnd[31:8], 4'h1, n}, 33'h0);
    if (n[3] != n[2]) st[3] = n[3];
    if (n[1] != n[0]) st[7] = n[1];
    st = st & {1'b1, 1'b0, ~(n[1] | n[0]), 5'b11001};
    rd(st);
  endtask
  task automatic line(input int i);
    req[i] <= 1'b1;
    @(posedge pclk);
    req <= 4'h0;
    repeat (4) @(posedge pclk);
  endtask
  // Each finished transfer is compared with the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) chk(33'h0, 33'h1, "queue");
      else chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front(), "apb");
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00);
    apb(1'b0, irq_enable_addr, 32'h0, 33'h0);
    apb(1'b1, status_addr, 32'hff, {1'b1, 32'h0});
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    rnd = lfsr(rnd);
    // channel first started by control command
    for (int i = 0; i < 16; i++) ctl(i[3:0] ^ rnd[3:0]);
    ctl(4'ha);
    apb(1'b1, command_addr, 32'h22, 33'h0);
    rd(8'hc8);
    apb(1'b1, command_addr, 32'h21, 33'h0);
    rd(8'ha8);
    line(2);
    rd(8'h88);
    apb(1'b1, irq_clear_addr, 32'h7, 33'h0);
    apb(1'b1, irq_enable_addr, 32'h1, 33'h0);
    slow <= 1'b1;
    line(0);
    chk({32'h0, halted}, 33'h1, "halted");
    chk({32'h0, irq}, 33'h1, "irq");
    rd(8'h8c);
    apb(1'b0, irq_status_addr, 32'h0, 33'h1);
    line(1);
    rd(8'h8a);
    slow <= 1'b0;
    line(3);
    rd(8'h88);
    apb(1'b1, irq_clear_addr, 32'h1, 33'h0);
    @(posedge pclk);
    chk({32'h0, irq}, 33'h0, "irq");
    line(0);
    st = 8'h8c;
    ctl(4'h8);
    apb(1'b1, irq_enable_addr, 32'h0, 33'h0);
    @(posedge pclk);
    chk({32'h0, irq}, 33'h0, "irq");
    apb(1'b1, command_addr, 32'h80, 33'h0);
    rd(8'h00);
    apb(1'b1, command_addr, 32'h40, 33'h0);
    apb(1'b0, irq_status_addr, 32'h0, 33'h7);
    stop_test();
  end
endmodule // test_chan_ctl
`default_nettype wire
